// File: rtl/fur_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module fur_fifo #(
  parameter int W = 3,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,    // System clock
  input wire logic i_resetn,  // Sync reset, active low
  fur_stream_if.snk s_in,     // Filling side
  fur_stream_if.src s_out     // Draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire full = (cnt_q == (AW+1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire do_wr = s_in.valid & ~full;
  wire do_rd = s_out.ready & ~empty;
  assign s_in.ready = ~full;
  assign s_out.valid = ~empty;
  assign s_out.data = mem[rd_q];

  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wr_q] <= s_in.data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (do_rd) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
    end
  end
endmodule

// File: rtl/fur_pkg.sv
// Constants and types for the inductive FSK uplink receiver
package fur_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int F_ONE_HZ = 110_340;
  localparam int F_ZERO_HZ = 108_840;
  localparam int BIT_US = 800;
  localparam int GAP_US = 1200;
  localparam int MSG_MS = 40;
  localparam int MSG_BITS = 50;
  localparam int START_BITS = 2;
  localparam int DATA_BITS = MSG_BITS - START_BITS;
  localparam int BIT_CYC_DEF = BIT_US * (CLK_HZ / 1_000_000);
  localparam int GAP_CYC_DEF = GAP_US * (CLK_HZ / 1_000_000);
  localparam int MSG_CYC = MSG_MS * (CLK_HZ / 1000);
  localparam int WDOG_CYC_DEF = 2 * MSG_CYC;
  localparam int PER_W = 12;
  localparam int TMR_W = 17;
  localparam int GAP_W = 18;
  localparam int WD_W = 24;
  localparam int TAL_W = 8;
  localparam int IDX_W = 6;
  localparam int P_ONE = CLK_HZ / F_ONE_HZ;
  localparam int P_ZERO = CLK_HZ / F_ZERO_HZ;
  localparam int P_MID = (P_ONE + P_ZERO) / 2;
  localparam int P_TOL = 6;
  localparam logic [PER_W-1:0] ONE_LO = PER_W'(P_ONE - P_TOL);
  localparam logic [PER_W-1:0] ONE_HI = PER_W'(P_MID - 1);
  localparam logic [PER_W-1:0] ZERO_LO = PER_W'(P_MID);
  localparam logic [PER_W-1:0] ZERO_HI = PER_W'(P_ZERO + P_TOL);
  localparam logic [PER_W-1:0] ABSENT_CYC = PER_W'(4 * P_ZERO);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DATA_BITS - 1);
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_ONE = 2'h1;
  localparam logic [1:0] CODE_ZERO = 2'h2;
  localparam int WORD_W = 3;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {
    FUR_HUNT = 2'b00,
    FUR_ARMED = 2'b01,
    FUR_BITS = 2'b10
  } fur_state_t;
endpackage

// File: rtl/fur_receiver.sv
// Two-antenna digital FSK uplink demodulator with message framing
// Function
// - Message is fifty return-to-zero bit periods
// - Upper carrier means one, lower means zero
// - Two carrier-free bits mark message start
// - One message every forty milliseconds
// - Forty-eight data bits follow start gap
// - Bit lasts 800 us, 1250 bit/s
// - Forward antenna data used for control; rear bits are output instead while only the rear channel holds sync
// - Rear receiver drives proceed clock only while the rear channel alone holds sync
// - Measure each carrier cycle, decide per cycle
// - Up counter times zero crossing intervals
// - Decoder maps period count to frequency code
// - Accumulate decisions, dump and output at end
// - Output most frequent code, strobed out
// - Tolerate four short impulses per bit
// - Each cycle checked against both valid frequencies
`timescale 1ns/1ps
module fur_receiver
  import fur_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_DEF,
  parameter int GAP_CYC = GAP_CYC_DEF,
  parameter int WDOG_CYC = WDOG_CYC_DEF
) (
  input wire logic i_mclk,                    // 100 MHz clock
  input wire logic i_resetn,                  // Sync reset, active low
  input wire logic i_fwd_carrier,             // Squared carrier, forward antenna
  input wire logic i_rear_carrier,            // Squared carrier, rear antenna
  input wire logic i_bit_ready,               // Consumer takes a bit word
  output logic o_bit_valid,                   // Bit word available
  output logic o_bit_data,                    // Decoded data bit
  output logic o_bit_last,                    // Last data bit of message
  output logic o_bit_rear,                    // Bit came from rear antenna
  output logic o_proceed_permit_clock,        // Carrier envelope of chosen antenna
  output logic o_fwd_sync,                    // Forward channel framed
  output logic o_rear_sync,                   // Rear channel framed
  output logic o_overrun                      // Bit lost, FIFO full
);
  wire [1:0] carrier_in = {i_rear_carrier, i_fwd_carrier};

  logic [1:0] sq_q;
  logic [PER_W-1:0] per_q [2];
  logic [GAP_W-1:0] gap_q [2];
  logic [TMR_W-1:0] tmr_q [2];
  logic [WD_W-1:0] wd_q [2];
  logic [TAL_W-1:0] ones_q [2];
  logic [TAL_W-1:0] zeros_q [2];
  logic [IDX_W-1:0] idx_q [2];
  fur_state_t st_q [2];
  logic [1:0] sync_q;
  logic [1:0] stb_q;
  logic [1:0] bit_q;
  logic [1:0] last_q;
  logic [1:0] edge_w;
  logic [1:0] env_w;
  logic [1:0] bit_end_w;
  logic [1:0] code_w [2];
  logic overrun_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire in_one = (per_q[g] >= ONE_LO) && (per_q[g] <= ONE_HI);
      wire in_zero = (per_q[g] >= ZERO_LO) && (per_q[g] <= ZERO_HI);
      // Rising edge closes one full carrier cycle
      assign edge_w[g] = carrier_in[g] & ~sq_q[g];
      // Code is valid only on the edge that ends a cycle
      assign code_w[g] = !edge_w[g] ? CODE_NONE : in_one ? CODE_ONE :
        in_zero ? CODE_ZERO : CODE_NONE;
      // Carrier off once no edge for four slow periods
      assign env_w[g] = (per_q[g] < ABSENT_CYC);
      assign bit_end_w[g] = (st_q[g] == FUR_BITS) && (tmr_q[g] == TMR_W'(BIT_CYC - 1));

      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          sq_q[g] <= 1'b0;
          per_q[g] <= '1;
          gap_q[g] <= '0;
        end else begin
          sq_q[g] <= carrier_in[g];
          // Saturating so an idle link reads as carrier absent
          per_q[g] <= edge_w[g] ? PER_W'(1) : (&per_q[g]) ? per_q[g] : PER_W'(per_q[g] + 1'b1);
          gap_q[g] <= env_w[g] ? '0 : (&gap_q[g]) ? gap_q[g] : GAP_W'(gap_q[g] + 1'b1);
        end
      end

      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          st_q[g] <= FUR_HUNT;
          tmr_q[g] <= '0;
          idx_q[g] <= '0;
          ones_q[g] <= '0;
          zeros_q[g] <= '0;
          stb_q[g] <= 1'b0;
          bit_q[g] <= 1'b0;
          last_q[g] <= 1'b0;
        end else begin
          stb_q[g] <= bit_end_w[g];
          case (st_q[g])
            FUR_HUNT: begin
              // Half-bit gaps are too short to pass this
              if (gap_q[g] >= GAP_W'(GAP_CYC)) begin
                st_q[g] <= FUR_ARMED;
              end
            end
            FUR_ARMED: begin
              if (edge_w[g]) begin
                st_q[g] <= FUR_BITS;
                tmr_q[g] <= '0;
                idx_q[g] <= '0;
                ones_q[g] <= '0;
                zeros_q[g] <= '0;
              end
            end
            FUR_BITS: begin
              if (bit_end_w[g]) begin
                // Tie goes to zero; invalid cycles never vote
                bit_q[g] <= (ones_q[g] > zeros_q[g]);
                last_q[g] <= (idx_q[g] == LAST_IDX);
                ones_q[g] <= '0;
                zeros_q[g] <= '0;
                tmr_q[g] <= '0;
                // Wrap so the index never points past the frame
                idx_q[g] <= (idx_q[g] == LAST_IDX) ? '0 : IDX_W'(idx_q[g] + 1'b1);
                if (idx_q[g] == LAST_IDX) begin
                  st_q[g] <= FUR_HUNT;
                end
              end else begin
                tmr_q[g] <= TMR_W'(tmr_q[g] + 1'b1);
                if (code_w[g] == CODE_ONE && !(&ones_q[g])) begin
                  ones_q[g] <= TAL_W'(ones_q[g] + 1'b1);
                end
                if (code_w[g] == CODE_ZERO && !(&zeros_q[g])) begin
                  zeros_q[g] <= TAL_W'(zeros_q[g] + 1'b1);
                end
              end
            end
            default: begin
              st_q[g] <= FUR_HUNT;
            end
          endcase
        end
      end

      // Sync drops if complete messages stop arriving at the frame rate
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          sync_q[g] <= 1'b0;
          wd_q[g] <= '0;
        end else if (bit_end_w[g] && idx_q[g] == LAST_IDX) begin
          sync_q[g] <= 1'b1;
          wd_q[g] <= '0;
        end else if (wd_q[g] >= WD_W'(WDOG_CYC)) begin
          sync_q[g] <= 1'b0;
        end else begin
          wd_q[g] <= WD_W'(wd_q[g] + 1'b1);
        end
      end

      a_code_legal: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        code_w[g] != 2'h3) else $error("illegal frequency code");
      a_invalid_no_vote: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (st_q[g] == FUR_BITS && !bit_end_w[g] && code_w[g] == CODE_NONE)
        |=> ($stable(ones_q[g]) && $stable(zeros_q[g]))) else $error("invalid cycle counted");
      a_bit_length: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (st_q[g] == FUR_ARMED && edge_w[g]) |=> (st_q[g] == FUR_BITS && tmr_q[g] == '0))
        else $error("bit timer not aligned");
      a_majority_out: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        bit_end_w[g] |=> (stb_q[g] && bit_q[g] == ($past(ones_q[g]) > $past(zeros_q[g]))))
        else $error("output bit not majority");
      a_frame_len: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        idx_q[g] <= LAST_IDX) else $error("frame exceeds data bits");
      a_tally_dump: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        bit_end_w[g] |=> (ones_q[g] == '0 && zeros_q[g] == '0)) else $error("tally not dumped");
    end
  endgenerate

  // Forward unless only the rear channel holds frame sync
  wire use_fwd = sync_q[0] | ~sync_q[1];
  wire push_w = use_fwd ? stb_q[0] : stb_q[1];
  wire [WORD_W-1:0] word_w = use_fwd ? {1'b0, last_q[0], bit_q[0]} : {1'b1, last_q[1], bit_q[1]};

  fur_stream_if #(.W(WORD_W)) s_in ();
  fur_stream_if #(.W(WORD_W)) s_out ();
  assign s_in.valid = push_w;
  assign s_in.data = word_w;
  assign s_out.ready = i_bit_ready;

  fur_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) fur_fifo_inst (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .s_in(s_in),
    .s_out(s_out)
  );

  // Link cannot be paused, so a full FIFO loses the bit and flags it
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= push_w & ~s_in.ready;
    end
  end

  assign o_bit_valid = s_out.valid;
  assign o_bit_data = s_out.data[0];
  assign o_bit_last = s_out.data[1];
  assign o_bit_rear = s_out.data[2];
  // Rear envelope bridges loop boundaries when only the rear channel holds sync
  assign o_proceed_permit_clock = use_fwd ? env_w[0] : env_w[1];
  assign o_fwd_sync = sync_q[0];
  assign o_rear_sync = sync_q[1];
  assign o_overrun = overrun_q;

  a_fwd_priority: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (sync_q[0] && push_w) |-> (word_w[2] == 1'b0 && push_w == stb_q[0])) else $error("rear used while forward synced");
  a_ppc_select: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!sync_q[0] && sync_q[1]) |-> (o_proceed_permit_clock == env_w[1])) else $error("proceed clock not from rear");
  a_overrun_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (push_w && !s_in.ready) |=> o_overrun) else $error("lost bit not flagged");
endmodule

// File: rtl/fur_stream_if.sv
// Valid/ready word stream between receiver modules
`timescale 1ns/1ps
interface fur_stream_if #(parameter int W = 3);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: verif/fur_tx_model.sv
// Behavioural wayside transmitter driving a squared FSK carrier
`timescale 1ns/1ps
module fur_tx_model
  import fur_pkg::*;
#(
  parameter int BIT_CYC = 2000
) (
  input wire logic i_mclk,          // Bench clock
  input wire logic i_go,            // Start one message
  input wire logic [47:0] i_word,   // Data bits, first sent is bit 47
  output logic o_carrier,           // Squared carrier
  output logic o_busy               // Message in flight
);
  int per;
  initial begin
    o_carrier = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_mclk iff i_go);
      #1;
      o_busy = 1'b1;
      // Carrier stays off for the two start bits
      repeat (START_BITS * BIT_CYC) @(posedge i_mclk);
      #1;
      for (int b = 0; b < DATA_BITS; b++) begin
        per = i_word[47 - b] ? P_ONE : P_ZERO;
        for (int t = 0; t < BIT_CYC; t++) begin
          // Energy only in the first half of the bit
          o_carrier = (t < BIT_CYC / 2) && ((t % per) < per / 2);
          @(posedge i_mclk);
          #1;
        end
      end
      o_carrier = 1'b0;
      o_busy = 1'b0;
    end
  end
endmodule

// File: verif/tb_fur_receiver.sv
// Self-checking bench: one framed message, FIFO overrun, sync and envelope
`timescale 1ns/1ps
module tb_fur_receiver;
  import fur_pkg::*;
  // Shortened bit so one message fits the run; carrier timing stays real
  localparam int TB_BIT = 1900;
  localparam int TB_GAP = 3000;
  localparam int TB_LIMIT = 100000;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_bit_ready = 1'b0;
  logic carrier;
  logic go = 1'b0;
  logic busy;
  logic [47:0] word = 48'h0;
  logic o_bit_valid, o_bit_data, o_bit_last, o_bit_rear;
  logic o_proceed_permit_clock, o_fwd_sync, o_rear_sync, o_overrun;
  logic rdy_en = 1'b0;
  logic [2:0] exp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int ovr = 0;
  int pops = 0;
  int cyc = 0;

  always #5 i_mclk = ~i_mclk;

  fur_tx_model #(.BIT_CYC(TB_BIT)) fur_tx_model_inst (
    .i_mclk(i_mclk), .i_go(go), .i_word(word), .o_carrier(carrier), .o_busy(busy));

  // Rear antenna sees the same loop, so both channels frame
  fur_receiver #(.BIT_CYC(TB_BIT), .GAP_CYC(TB_GAP), .WDOG_CYC(2 * 50 * TB_BIT)) fur_receiver_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_fwd_carrier(carrier), .i_rear_carrier(carrier),
    .i_bit_ready(i_bit_ready), .o_bit_valid(o_bit_valid), .o_bit_data(o_bit_data),
    .o_bit_last(o_bit_last), .o_bit_rear(o_bit_rear), .o_proceed_permit_clock(o_proceed_permit_clock),
    .o_fwd_sync(o_fwd_sync), .o_rear_sync(o_rear_sync), .o_overrun(o_overrun));

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Consumer stalls until two bits were dropped, then takes words at random
  always @(posedge i_mclk) begin
    #1;
    i_bit_ready = rdy_en ? 1'($urandom % 2) : 1'b0;
  end

  // Falling edge: outputs settled, and a word seen here is popped at the next rise
  always @(negedge i_mclk) begin
    cyc++;
    if (cyc == TB_LIMIT) begin
      fails++;
      $display("Error at %0t: timeout", $time);
      complete_run();
    end else if (i_resetn === 1'b1) begin
      if (o_overrun === 1'b1) begin
        ovr++;
      end
      if (o_bit_valid === 1'b1 && i_bit_ready === 1'b1) begin
        pops++;
        if (exp_q.size() == 0) begin
          chk(1'b0, "word with nothing expected");
        end else begin
          chk({o_bit_rear, o_bit_last, o_bit_data} === exp_q.pop_front(), "bit word mismatch");
        end
      end
    end
  end

  initial begin
    void'($urandom(24493));
    word = {16'($urandom), $urandom};
    repeat (8) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    chk(o_bit_valid === 1'b0, "valid after reset");
    // Bits 8 and 9 arrive while the FIFO holds 8 words and are lost
    for (int b = 0; b < DATA_BITS; b++) begin
      if (b != 8 && b != 9) begin
        exp_q.push_back({1'b0, b == DATA_BITS - 1, word[47 - b]});
      end
    end
    @(posedge i_mclk);
    #1;
    go = 1'b1;
    @(posedge i_mclk);
    #1;
    go = 1'b0;
    repeat (START_BITS * TB_BIT - 200) @(posedge i_mclk);
    #1;
    chk(o_proceed_permit_clock === 1'b0, "envelope high in start gap");
    repeat (300) @(posedge i_mclk);
    #1;
    chk(o_proceed_permit_clock === 1'b1, "envelope low with carrier");
    chk(o_fwd_sync === 1'b0, "sync before full message");
    wait (ovr == 2 || cyc > TB_LIMIT - 1000);
    chk(o_bit_valid === 1'b1, "stored words lost on overrun");
    rdy_en = 1'b1;
    wait (busy === 1'b0);
    repeat (200) @(posedge i_mclk);
    #1;
    chk(exp_q.size() == 0, "words missing");
    chk(pops == DATA_BITS - 2, "word count");
    chk(ovr == 2, "overrun count");
    chk(o_fwd_sync === 1'b1, "forward not framed");
    chk(o_rear_sync === 1'b1, "rear not framed");
    chk(o_bit_valid === 1'b0, "FIFO not drained");
    complete_run();
  end
endmodule
